// *** rtl/debug_breakpoint_consts.vh ***
// constants for the tile debug register bank
`ifndef DEBUG_BREAKPOINT_CONSTS_VH
`define DEBUG_BREAKPOINT_CONSTS_VH

// register indices on the debug register port
`define DBG_IDX_TARGET_SEL   8'h14
`define DBG_IDX_CAUSE        8'h15
`define DBG_IDX_INFO         8'h16
`define DBG_IDX_STOP_MASK    8'h18
`define DBG_IDX_SCRATCH      8'h20
`define DBG_IDX_IBRK_ADDR    8'h30
`define DBG_IDX_IBRK_CTRL    8'h40
`define DBG_IDX_DW_ADDR1     8'h50
`define DBG_IDX_DW_ADDR2     8'h60
`define DBG_IDX_DW_CTRL      8'h70

// group decodes: scratch uses index[7:3], breakpoint banks index[7:2]
`define DBG_GRP8_SCRATCH     5'h04
`define DBG_GRP4_IBRK_ADDR   6'h0C
`define DBG_GRP4_IBRK_CTRL   6'h10
`define DBG_GRP4_DW_ADDR1    6'h14
`define DBG_GRP4_DW_ADDR2    6'h18
`define DBG_GRP4_DW_CTRL     6'h1C

// scratch window in the tile configuration space
`define CFG_GRP8_SCRATCH     5'h04

// writable bit masks, reserved bits stay zero
`define DBG_MASK_TARGET_SEL  32'h0000001F
`define DBG_MASK_CAUSE       32'h0003FF07
`define DBG_MASK_STOP        32'h000000FF
`define DBG_MASK_IBRK_CTRL   32'h00FF0003
`define DBG_MASK_DW_CTRL     32'h00FF0007

// field positions
`define DBG_CAUSE_LSB        0
`define DBG_THREAD_LSB       8
`define DBG_BRKNUM_LSB       16
`define DBG_CTRL_ENABLE      0
`define DBG_CTRL_COND        1
`define DBG_CTRL_LOAD        2
`define DBG_CTRL_THR_LSB     16

// cause codes
`define DBG_CAUSE_HOST       3'h1
`define DBG_CAUSE_TRAP       3'h2
`define DBG_CAUSE_IBREAK     3'h3
`define DBG_CAUSE_DWATCH     3'h4
`define DBG_CAUSE_RWATCH     3'h5

// reset values
`define DBG_RESET_WORD       32'h00000000
`define DBG_RESET_MASK8      8'h00

`endif

// *** rtl/debug_breakpoint_regs.v ***
// tile debug register bank with breakpoints and watchpoints
//
// Summary of operation
// [R01] five-bit target register index, upper bits reserved
// [R02] record three-bit cause code on debug interrupt
// [R03] record breakpoint number, zero for host/trap
// [R04] simultaneous hits report the lowest number
// [R05] record causing thread, zero for host
// [R06] capture access address or resource identifier
// [R07] per-thread stop mask holds threads outside debug
// [R08] masked threads stay suspended after debug return
// [R09] eight scratch words, also in config space
// [R10] compare program counter with enabled breakpoints
// [R11] four breakpoints, own address and control
// [R12] per-thread enable field, reset to zero
// [R13] condition bit selects equal or unequal match
// [R14] bit zero enables breakpoint, reset to zero
// [R15] four data watch first-address registers
// [R16] four data watch second-address registers
// [R17] condition bit selects and or or
// [R18] fire only for enabled thread and breakpoint
// [R19] reserved bits read zero, writes ignored
`include "debug_breakpoint_consts.vh"
module debug_breakpoint_regs (
  input  wire        SYS_CLK_IN,            // core clock
  input  wire        RST_N_IN,              // synchronous reset, active low
  input  wire        REG_WR_IN,             // debug register write strobe
  input  wire        REG_RD_IN,             // debug register read strobe
  input  wire [7:0]  REG_ADDR_IN,           // debug register index
  input  wire [31:0] REG_WDATA_IN,          // debug register write data
  output reg  [31:0] REG_RDATA_OUT,         // debug register read data
  output reg         REG_RVALID_OUT,        // read data valid pulse
  input  wire        CFG_WR_IN,             // tile config write strobe
  input  wire        CFG_RD_IN,             // tile config read strobe
  input  wire [7:0]  CFG_ADDR_IN,           // tile config index
  input  wire [31:0] CFG_WDATA_IN,          // tile config write data
  output reg  [31:0] CFG_RDATA_OUT,         // tile config read data
  output reg         CFG_RVALID_OUT,        // config read valid pulse
  input  wire        HOST_REQ_IN,           // host debug request pulse
  input  wire        TRAP_VALID_IN,         // debug trap instruction issued
  input  wire [2:0]  TRAP_THREAD_IN,        // thread of the trap
  input  wire        PC_VALID_IN,           // instruction issue
  input  wire [31:0] PC_IN,                 // program counter
  input  wire [2:0]  PC_THREAD_IN,          // thread of the instruction
  input  wire        MEM_VALID_IN,          // memory access issue
  input  wire        MEM_LOAD_IN,           // access is a load
  input  wire [31:0] MEM_ADDR_IN,           // effective address
  input  wire [2:0]  MEM_THREAD_IN,         // thread of the access
  input  wire        RES_HIT_IN,            // resource watch hit
  input  wire [1:0]  RES_INDEX_IN,          // resource watch number
  input  wire [31:0] RES_ID_IN,             // resource identifier
  input  wire [2:0]  RES_THREAD_IN,         // thread of the resource hit
  input  wire        DEBUG_RETURN_IN,       // return from debug pulse
  output reg         DEBUG_INT_OUT,         // debug interrupt pulse
  output reg         DEBUG_MODE_OUT,        // tile in debug mode
  output reg  [7:0]  THREAD_HOLD_OUT,       // threads kept from running
  output reg  [4:0]  TARGET_REG_INDEX_OUT   // register index for fetch
);

  // register storage
  reg  [31:0]  target_sel_reg;
  reg  [31:0]  target_sel_next;
  reg  [31:0]  cause_reg;
  reg  [31:0]  cause_next;
  reg  [31:0]  info_reg;
  reg  [31:0]  info_next;
  reg  [7:0]   stop_mask_reg;
  reg  [7:0]   stop_mask_next;
  reg          debug_mode_reg;
  reg          debug_mode_next;
  reg  [31:0]  scratch_reg [0:7];
  reg  [31:0]  ibrk_addr_reg [0:3];
  reg  [31:0]  ibrk_ctrl_reg [0:3];
  reg  [31:0]  dw_addr1_reg [0:3];
  reg  [31:0]  dw_addr2_reg [0:3];
  reg  [31:0]  dw_ctrl_reg [0:3];

  // flattened views and per-entry strobes
  wire [127:0] ibrk_addr_flat;
  wire [127:0] ibrk_ctrl_flat;
  wire [127:0] dw_addr1_flat;
  wire [127:0] dw_addr2_flat;
  wire [127:0] dw_ctrl_flat;
  wire [7:0]   scr_reg_we;
  wire [7:0]   scr_cfg_we;
  wire [3:0]   ibrk_addr_we;
  wire [3:0]   ibrk_ctrl_we;
  wire [3:0]   dw_addr1_we;
  wire [3:0]   dw_addr2_we;
  wire [3:0]   dw_ctrl_we;
  wire [3:0]   ibrk_hit;
  wire [3:0]   dw_hit;

  // event selection
  reg          ev_fire;
  reg  [2:0]   ev_cause;
  reg  [2:0]   ev_thread;
  reg  [1:0]   ev_num;
  reg          ev_data_we;
  reg  [31:0]  ev_data;
  reg  [31:0]  reg_rd_mux;
  reg  [31:0]  cfg_rd_mux;

  integer      k;

  wire         wr_target  = REG_WR_IN & (REG_ADDR_IN == `DBG_IDX_TARGET_SEL);
  wire         wr_cause   = REG_WR_IN & (REG_ADDR_IN == `DBG_IDX_CAUSE);
  wire         wr_info    = REG_WR_IN & (REG_ADDR_IN == `DBG_IDX_INFO);
  wire         wr_stop    = REG_WR_IN & (REG_ADDR_IN == `DBG_IDX_STOP_MASK);
  wire         reg_scr    = (REG_ADDR_IN[7:3] == `DBG_GRP8_SCRATCH);
  wire         cfg_scr    = (CFG_ADDR_IN[7:3] == `CFG_GRP8_SCRATCH);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_scr
      assign scr_reg_we[g] = REG_WR_IN & reg_scr & (REG_ADDR_IN[2:0] == g);  // [R09]
      assign scr_cfg_we[g] = CFG_WR_IN & cfg_scr & (CFG_ADDR_IN[2:0] == g);  // [R09]
    end
    for (g = 0; g < 4; g = g + 1) begin : g_brk
      assign ibrk_addr_we[g] = REG_WR_IN & (REG_ADDR_IN[7:2] == `DBG_GRP4_IBRK_ADDR) & (REG_ADDR_IN[1:0] == g);
      assign ibrk_ctrl_we[g] = REG_WR_IN & (REG_ADDR_IN[7:2] == `DBG_GRP4_IBRK_CTRL) & (REG_ADDR_IN[1:0] == g);
      assign dw_addr1_we[g]  = REG_WR_IN & (REG_ADDR_IN[7:2] == `DBG_GRP4_DW_ADDR1) & (REG_ADDR_IN[1:0] == g);
      assign dw_addr2_we[g]  = REG_WR_IN & (REG_ADDR_IN[7:2] == `DBG_GRP4_DW_ADDR2) & (REG_ADDR_IN[1:0] == g);
      assign dw_ctrl_we[g]   = REG_WR_IN & (REG_ADDR_IN[7:2] == `DBG_GRP4_DW_CTRL) & (REG_ADDR_IN[1:0] == g);
      assign ibrk_addr_flat[32*g +: 32] = ibrk_addr_reg[g];  // [R11]
      assign ibrk_ctrl_flat[32*g +: 32] = ibrk_ctrl_reg[g];  // [R11]
      assign dw_addr1_flat[32*g +: 32]  = dw_addr1_reg[g];
      assign dw_addr2_flat[32*g +: 32]  = dw_addr2_reg[g];
      assign dw_ctrl_flat[32*g +: 32]   = dw_ctrl_reg[g];
    end
  endgenerate

  ibreak_match u_ibreak (
    .pc_valid_in  (PC_VALID_IN),
    .pc_in        (PC_IN),
    .thread_in    (PC_THREAD_IN),
    .addr_flat_in (ibrk_addr_flat),
    .ctrl_flat_in (ibrk_ctrl_flat),
    .hit_out      (ibrk_hit)
  );

  dwatch_match u_dwatch (
    .mem_valid_in  (MEM_VALID_IN),
    .mem_load_in   (MEM_LOAD_IN),
    .mem_addr_in   (MEM_ADDR_IN),
    .thread_in     (MEM_THREAD_IN),
    .addr1_flat_in (dw_addr1_flat),
    .addr2_flat_in (dw_addr2_flat),
    .ctrl_flat_in  (dw_ctrl_flat),
    .hit_out       (dw_hit)
  );

  // lowest set bit of a hit vector
  function [1:0] lowest_hit;
    input [3:0] v;
    begin
      if (v[0])
        lowest_hit = 2'h0;
      else if (v[1])
        lowest_hit = 2'h1;
      else if (v[2])
        lowest_hit = 2'h2;
      else
        lowest_hit = 2'h3;
    end
  endfunction

  // pick one debug event; nothing is taken while already in debug mode
  always @* begin
    ev_fire    = 1'b0;
    ev_cause   = 3'h0;
    ev_thread  = 3'h0;
    ev_num     = 2'h0;
    ev_data_we = 1'b0;
    ev_data    = `DBG_RESET_WORD;
    if (!debug_mode_reg) begin
      if (HOST_REQ_IN) begin
        ev_fire  = 1'b1;
        ev_cause = `DBG_CAUSE_HOST;  // [R02] [R03] [R05]
      end else if (TRAP_VALID_IN) begin
        ev_fire   = 1'b1;
        ev_cause  = `DBG_CAUSE_TRAP;  // [R02] [R03]
        ev_thread = TRAP_THREAD_IN;  // [R05]
      end else if (|ibrk_hit) begin
        ev_fire   = 1'b1;
        ev_cause  = `DBG_CAUSE_IBREAK;  // [R02] [R10]
        ev_thread = PC_THREAD_IN;  // [R05]
        ev_num    = lowest_hit(ibrk_hit);  // [R03] [R04]
      end else if (|dw_hit) begin
        ev_fire    = 1'b1;
        ev_cause   = `DBG_CAUSE_DWATCH;  // [R02]
        ev_thread  = MEM_THREAD_IN;  // [R05]
        ev_num     = lowest_hit(dw_hit);  // [R03] [R04]
        ev_data_we = 1'b1;
        ev_data    = MEM_ADDR_IN;  // [R06]
      end else if (RES_HIT_IN) begin
        ev_fire    = 1'b1;
        ev_cause   = `DBG_CAUSE_RWATCH;  // [R02]
        ev_thread  = RES_THREAD_IN;  // [R05]
        ev_num     = RES_INDEX_IN;  // [R03]
        ev_data_we = 1'b1;
        ev_data    = RES_ID_IN;  // [R06]
      end
    end
  end

  // next values for single registers; hardware capture beats a software write
  always @* begin
    target_sel_next = target_sel_reg;
    if (wr_target)
      target_sel_next = REG_WDATA_IN & `DBG_MASK_TARGET_SEL;  // [R01] [R19]
    cause_next = cause_reg;
    if (ev_fire) begin
      cause_next = `DBG_RESET_WORD;
      cause_next[`DBG_CAUSE_LSB +: 3]  = ev_cause;  // [R02]
      cause_next[`DBG_THREAD_LSB +: 8] = {5'h00, ev_thread};  // [R05]
      cause_next[`DBG_BRKNUM_LSB +: 2] = ev_num;  // [R03]
    end else if (wr_cause) begin
      cause_next = REG_WDATA_IN & `DBG_MASK_CAUSE;  // [R19]
    end
    info_next = info_reg;
    if (ev_data_we)
      info_next = ev_data;  // [R06]
    else if (wr_info)
      info_next = REG_WDATA_IN;
    stop_mask_next = stop_mask_reg;
    if (wr_stop)
      stop_mask_next = REG_WDATA_IN[7:0];  // [R07]
    debug_mode_next = debug_mode_reg;
    if (ev_fire)
      debug_mode_next = 1'b1;
    else if (DEBUG_RETURN_IN)
      debug_mode_next = 1'b0;
  end

  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      target_sel_reg <= `DBG_RESET_WORD;
      cause_reg      <= `DBG_RESET_WORD;
      info_reg       <= `DBG_RESET_WORD;
      stop_mask_reg  <= `DBG_RESET_MASK8;
      debug_mode_reg <= 1'b0;
    end else begin
      target_sel_reg <= target_sel_next;
      cause_reg      <= cause_next;
      info_reg       <= info_next;
      stop_mask_reg  <= stop_mask_next;
      debug_mode_reg <= debug_mode_next;
    end
  end

  // indexed storage; the debug port wins a same-cycle scratch collision
  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      for (k = 0; k < 8; k = k + 1)
        scratch_reg[k] <= `DBG_RESET_WORD;
      for (k = 0; k < 4; k = k + 1) begin
        ibrk_addr_reg[k] <= `DBG_RESET_WORD;
        ibrk_ctrl_reg[k] <= `DBG_RESET_WORD;  // [R12] [R13] [R14]
        dw_addr1_reg[k]  <= `DBG_RESET_WORD;
        dw_addr2_reg[k]  <= `DBG_RESET_WORD;
        dw_ctrl_reg[k]   <= `DBG_RESET_WORD;
      end
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        if (scr_reg_we[k])
          scratch_reg[k] <= REG_WDATA_IN;  // [R09]
        else if (scr_cfg_we[k])
          scratch_reg[k] <= CFG_WDATA_IN;  // [R09]
      end
      for (k = 0; k < 4; k = k + 1) begin
        if (ibrk_addr_we[k])
          ibrk_addr_reg[k] <= REG_WDATA_IN;  // [R11]
        if (ibrk_ctrl_we[k])
          ibrk_ctrl_reg[k] <= REG_WDATA_IN & `DBG_MASK_IBRK_CTRL;  // [R11] [R19]
        if (dw_addr1_we[k])
          dw_addr1_reg[k] <= REG_WDATA_IN;  // [R15]
        if (dw_addr2_we[k])
          dw_addr2_reg[k] <= REG_WDATA_IN;  // [R16]
        if (dw_ctrl_we[k])
          dw_ctrl_reg[k] <= REG_WDATA_IN & `DBG_MASK_DW_CTRL;  // [R17] [R19]
      end
    end
  end

  // read decode; unmapped indices read zero
  always @* begin
    reg_rd_mux = `DBG_RESET_WORD;
    case (REG_ADDR_IN[7:2])
      `DBG_GRP4_IBRK_ADDR: reg_rd_mux = ibrk_addr_reg[REG_ADDR_IN[1:0]];
      `DBG_GRP4_IBRK_CTRL: reg_rd_mux = ibrk_ctrl_reg[REG_ADDR_IN[1:0]];
      `DBG_GRP4_DW_ADDR1:  reg_rd_mux = dw_addr1_reg[REG_ADDR_IN[1:0]];
      `DBG_GRP4_DW_ADDR2:  reg_rd_mux = dw_addr2_reg[REG_ADDR_IN[1:0]];
      `DBG_GRP4_DW_CTRL:   reg_rd_mux = dw_ctrl_reg[REG_ADDR_IN[1:0]];
      default: begin
        if (reg_scr)
          reg_rd_mux = scratch_reg[REG_ADDR_IN[2:0]];  // [R09]
        else if (REG_ADDR_IN == `DBG_IDX_TARGET_SEL)
          reg_rd_mux = target_sel_reg;  // [R01]
        else if (REG_ADDR_IN == `DBG_IDX_CAUSE)
          reg_rd_mux = cause_reg;
        else if (REG_ADDR_IN == `DBG_IDX_INFO)
          reg_rd_mux = info_reg;
        else if (REG_ADDR_IN == `DBG_IDX_STOP_MASK)
          reg_rd_mux = {24'h000000, stop_mask_reg};  // [R19]
        else
          reg_rd_mux = `DBG_RESET_WORD;
      end
    endcase
    cfg_rd_mux = `DBG_RESET_WORD;
    if (cfg_scr)
      cfg_rd_mux = scratch_reg[CFG_ADDR_IN[2:0]];  // [R09]
  end

  // registered outputs
  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT        <= `DBG_RESET_WORD;
      REG_RVALID_OUT       <= 1'b0;
      CFG_RDATA_OUT        <= `DBG_RESET_WORD;
      CFG_RVALID_OUT       <= 1'b0;
      DEBUG_INT_OUT        <= 1'b0;
      DEBUG_MODE_OUT       <= 1'b0;
      THREAD_HOLD_OUT      <= `DBG_RESET_MASK8;
      TARGET_REG_INDEX_OUT <= 5'h00;
    end else begin
      REG_RDATA_OUT        <= REG_RD_IN ? reg_rd_mux : `DBG_RESET_WORD;
      REG_RVALID_OUT       <= REG_RD_IN;
      CFG_RDATA_OUT        <= CFG_RD_IN ? cfg_rd_mux : `DBG_RESET_WORD;
      CFG_RVALID_OUT       <= CFG_RD_IN;
      DEBUG_INT_OUT        <= ev_fire;
      DEBUG_MODE_OUT       <= debug_mode_next;
      THREAD_HOLD_OUT      <= debug_mode_next ? `DBG_RESET_MASK8 : stop_mask_next;  // [R07] [R08]
      TARGET_REG_INDEX_OUT <= target_sel_next[4:0];  // [R01]
    end
  end

endmodule // debug_breakpoint_regs

// *** rtl/dwatch_match.v ***
// four data watchpoint comparators
`include "debug_breakpoint_consts.vh"
module dwatch_match (
  input  wire         mem_valid_in,   // a memory access issues
  input  wire         mem_load_in,    // access is a load
  input  wire [31:0]  mem_addr_in,    // effective address
  input  wire [2:0]   thread_in,      // issuing thread
  input  wire [127:0] addr1_flat_in,  // four first addresses
  input  wire [127:0] addr2_flat_in,  // four second addresses
  input  wire [127:0] ctrl_flat_in,   // four control words
  output wire [3:0]   hit_out         // per watchpoint hit
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_watch
      wire [31:0] a1_w   = addr1_flat_in[32*i +: 32];
      wire [31:0] a2_w   = addr2_flat_in[32*i +: 32];
      wire [31:0] ctrl_w = ctrl_flat_in[32*i +: 32];
      // condition a: at or above first, b: at or below second
      wire        ca_w   = (mem_addr_in >= a1_w);  // [R15]
      wire        cb_w   = (mem_addr_in <= a2_w);  // [R16]
      wire        comb_w = ctrl_w[`DBG_CTRL_COND] ? (ca_w | cb_w) : (ca_w & cb_w);  // [R17]
      wire        kind_w = ctrl_w[`DBG_CTRL_LOAD] ? mem_load_in : ~mem_load_in;
      wire        thr_w  = ctrl_w[`DBG_CTRL_THR_LSB + thread_in];
      assign hit_out[i] = mem_valid_in & ctrl_w[`DBG_CTRL_ENABLE] & thr_w & kind_w & comb_w;
    end
  endgenerate
endmodule // dwatch_match

// *** rtl/ibreak_match.v ***
// four instruction breakpoint comparators
`include "debug_breakpoint_consts.vh"
module ibreak_match (
  input  wire         pc_valid_in,   // an instruction issues
  input  wire [31:0]  pc_in,         // its program counter
  input  wire [2:0]   thread_in,     // issuing thread
  input  wire [127:0] addr_flat_in,  // four compare addresses
  input  wire [127:0] ctrl_flat_in,  // four control words
  output wire [3:0]   hit_out        // per breakpoint hit
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_brk
      wire [31:0] addr_w = addr_flat_in[32*i +: 32];
      wire [31:0] ctrl_w = ctrl_flat_in[32*i +: 32];
      wire        eq_w   = (pc_in == addr_w);
      wire        thr_w  = ctrl_w[`DBG_CTRL_THR_LSB + thread_in];
      wire        cond_w = ctrl_w[`DBG_CTRL_COND] ? ~eq_w : eq_w;  // [R13]
      assign hit_out[i] = pc_valid_in & ctrl_w[`DBG_CTRL_ENABLE] & thr_w & cond_w;  // [R10] [R12] [R14] [R18]
    end
  endgenerate
endmodule // ibreak_match

// *** verif/core_pipe_model.sv ***
// core pipeline partner model
module core_pipe_model (
  input  wire logic   clk_in,       // core clock
  output logic        host_out,     // host request
  output logic        trap_out,     // trap issue
  output logic        pc_vld_out,   // instruction issue
  output logic        mem_vld_out,  // access issue
  output logic        res_out,      // resource hit
  output logic        ret_out,      // debug return
  output logic        load_out,     // access is load
  output logic [31:0] val_out,      // pc, address or id
  output logic [2:0]  thr_out,      // issuing thread
  output logic [1:0]  idx_out       // resource number
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ret_out, res_out, mem_vld_out, pc_vld_out, trap_out, host_out, load_out} = 7'h00;
    {val_out, thr_out, idx_out} = 37'h0;
  end
  // one-cycle issue, then inverted data
  task automatic fire(input int kind, input logic [31:0] v, input logic [2:0] t, input logic [1:0] i,
                      input logic ld);
    @(negedge clk_in);
    val_out = v;
    thr_out = t;
    idx_out = i;
    load_out = ld;
    {ret_out, res_out, mem_vld_out, pc_vld_out, trap_out, host_out} = 6'h01 << kind;
    @(negedge clk_in);
    {ret_out, res_out, mem_vld_out, pc_vld_out, trap_out, host_out} = 6'h00;
    {val_out, thr_out} = ~{v, t};
  endtask
endmodule // core_pipe_model

// *** verif/debug_breakpoint_regs_props.sv ***
// concurrent checks on the debug register bank ports
module debug_breakpoint_regs_props (
  input wire logic        SYS_CLK_IN,           // core clock
  input wire logic        RST_N_IN,             // reset, active low
  input wire logic        REG_WR_IN,            // write strobe
  input wire logic        REG_RD_IN,            // read strobe
  input wire logic [7:0]  REG_ADDR_IN,          // index
  input wire logic [31:0] REG_WDATA_IN,         // write data
  input wire logic [31:0] REG_RDATA_OUT,        // read data
  input wire logic        REG_RVALID_OUT,       // read valid
  input wire logic        CFG_RD_IN,            // config read
  input wire logic        CFG_RVALID_OUT,       // config valid
  input wire logic        HOST_REQ_IN,          // host request
  input wire logic        DEBUG_RETURN_IN,      // debug return
  input wire logic        DEBUG_INT_OUT,        // interrupt pulse
  input wire logic        DEBUG_MODE_OUT,       // debug mode
  input wire logic [7:0]  THREAD_HOLD_OUT,      // held threads
  input wire logic [4:0]  TARGET_REG_INDEX_OUT  // fetch index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_entry;
    DEBUG_INT_OUT && DEBUG_MODE_OUT && THREAD_HOLD_OUT == 8'h00;
  endsequence
  sequence s_leave;
    !DEBUG_MODE_OUT && !DEBUG_INT_OUT;
  endsequence
  property p_target;
    logic [4:0] v;
    (REG_WR_IN && REG_ADDR_IN == 8'h14, v = REG_WDATA_IN[4:0]) |=> TARGET_REG_INDEX_OUT == v;
  endproperty
  a_host_entry: assert property (HOST_REQ_IN && !DEBUG_MODE_OUT |=> s_entry)
    else $error("host request not taken");
  a_mode_hold: assert property (DEBUG_MODE_OUT |-> THREAD_HOLD_OUT == 8'h00)
    else $error("threads held in debug mode");
  a_return_leaves: assert property (DEBUG_MODE_OUT && DEBUG_RETURN_IN |=> s_leave)
    else $error("debug mode kept after return");
  a_mode_stays: assert property (DEBUG_MODE_OUT && !DEBUG_RETURN_IN |=> DEBUG_MODE_OUT && !DEBUG_INT_OUT)
    else $error("debug mode left early");
  a_mode_rise: assert property ($rose(DEBUG_MODE_OUT) |-> DEBUG_INT_OUT)
    else $error("mode entered without interrupt");
  a_int_pulse: assert property (DEBUG_INT_OUT |=> !DEBUG_INT_OUT)
    else $error("interrupt pulse too long");
  a_target_copy: assert property (p_target)
    else $error("target index not updated");
  a_unmapped_zero: assert property (REG_RD_IN && REG_ADDR_IN == 8'h17 |=> REG_RVALID_OUT && REG_RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_answer: assert property (CFG_RD_IN |=> CFG_RVALID_OUT)
    else $error("config read unanswered");
endmodule // debug_breakpoint_regs_props

bind debug_breakpoint_regs debug_breakpoint_regs_props i_props (
  .SYS_CLK_IN, .RST_N_IN, .REG_WR_IN, .REG_RD_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_RDATA_OUT,
  .REG_RVALID_OUT, .CFG_RD_IN, .CFG_RVALID_OUT, .HOST_REQ_IN, .DEBUG_RETURN_IN, .DEBUG_INT_OUT,
  .DEBUG_MODE_OUT, .THREAD_HOLD_OUT, .TARGET_REG_INDEX_OUT
);

// *** verif/debug_breakpoint_regs_tb_top.sv ***
// self-checking bench for the tile debug register bank
module debug_breakpoint_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        cfg_wr = 1'h0;
  logic        cfg_rd = 1'h0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic [7:0]  stop_exp = 8'h00;
  wire  [31:0] reg_rdata, cfg_rdata, val;
  wire         reg_rvalid, cfg_rvalid, host, trap, pc_vld, mem_vld, load, res, ret, dbg_int, dbg_mode;
  wire  [2:0]  thr;
  wire  [1:0]  idx;
  wire  [7:0]  hold;
  wire  [4:0]  tgt_idx;
  int          err_total = 0;
  int          n_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  core_pipe_model i_core (.clk_in(sys_clk), .host_out(host), .trap_out(trap), .pc_vld_out(pc_vld),
    .mem_vld_out(mem_vld), .res_out(res), .ret_out(ret), .load_out(load), .val_out(val), .thr_out(thr),
    .idx_out(idx));
  debug_breakpoint_regs i_dut (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(reg_rdata), .REG_RVALID_OUT(reg_rvalid),
    .CFG_WR_IN(cfg_wr), .CFG_RD_IN(cfg_rd), .CFG_ADDR_IN(cfg_addr), .CFG_WDATA_IN(cfg_wdata),
    .CFG_RDATA_OUT(cfg_rdata), .CFG_RVALID_OUT(cfg_rvalid), .HOST_REQ_IN(host), .TRAP_VALID_IN(trap),
    .TRAP_THREAD_IN(thr), .PC_VALID_IN(pc_vld), .PC_IN(val), .PC_THREAD_IN(thr), .MEM_VALID_IN(mem_vld),
    .MEM_LOAD_IN(load), .MEM_ADDR_IN(val), .MEM_THREAD_IN(thr), .RES_HIT_IN(res), .RES_INDEX_IN(idx),
    .RES_ID_IN(val), .RES_THREAD_IN(thr), .DEBUG_RETURN_IN(ret), .DEBUG_INT_OUT(dbg_int),
    .DEBUG_MODE_OUT(dbg_mode), .THREAD_HOLD_OUT(hold), .TARGET_REG_INDEX_OUT(tgt_idx));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic cfg, input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    {cfg_wr, reg_wr} = cfg ? 2'h2 : 2'h1;
    {cfg_addr, reg_addr} = {a, a};
    {cfg_wdata, reg_wdata} = {d, d};
    @(negedge sys_clk);
    {cfg_wr, reg_wr} = 2'h0;
  endtask
  task automatic rd(input logic cfg, input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    {cfg_rd, reg_rd} = cfg ? 2'h2 : 2'h1;
    {cfg_addr, reg_addr} = {a, a};
    @(negedge sys_clk);
    {cfg_rd, reg_rd} = 2'h0;
    chk({31'h0, cfg ? cfg_rvalid : reg_rvalid}, 32'h1);
    chk(cfg ? cfg_rdata : reg_rdata, exp);
  endtask
  // one core event, then hold, cause, info, return, hold
  task automatic take(input int kind, input logic [31:0] v, input logic [2:0] t, input logic ld,
                      input logic hit, input logic [31:0] cause);
    i_core.fire(kind, v, t, cause[17:16], ld);
    chk({31'h0, dbg_int}, {31'h0, hit});
    if (hit) begin
      chk({24'h0, hold}, 32'h0);
      rd(1'h0, 8'h15, cause);
      if (kind >= 3)
        rd(1'h0, 8'h16, v);
      i_core.fire(5, 32'h0, 3'h0, 2'h0, 1'h0);
      chk({31'h0, dbg_mode}, 32'h0);
      chk({24'h0, hold}, {24'h0, stop_exp});
    end
  endtask
  task automatic t_regs;
    rd(1'h0, 8'h15, 32'h0);
    for (int i = 0; i < 4; i++)
      rd(1'h0, 8'h40 + i[7:0], 32'h0);
    wr(1'h0, 8'h14, 32'hFFFFFFFF);
    rd(1'h0, 8'h14, 32'h0000001F);
    chk({27'h0, tgt_idx}, 32'h1F);
    wr(1'h0, 8'h15, 32'hFFFFFFFF);
    rd(1'h0, 8'h15, 32'h0003FF07);
    wr(1'h0, 8'h15, 32'h0);
    wr(1'h0, 8'h40, 32'hFFFFFFFE);
    rd(1'h0, 8'h40, 32'h00FF0002);
    wr(1'h0, 8'h40, 32'h0);
    wr(1'h0, 8'h17, 32'hFFFFFFFF);
    rd(1'h0, 8'h17, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(1'h0, 8'h30 + i[7:0], 32'hA5000000 + i);
      wr(1'h0, 8'h50 + i[7:0], 32'h5A000000 + i);
      wr(1'h0, 8'h60 + i[7:0], 32'h3C000000 + i);
    end
    for (int i = 0; i < 4; i++) begin
      rd(1'h0, 8'h30 + i[7:0], 32'hA5000000 + i);
      rd(1'h0, 8'h50 + i[7:0], 32'h5A000000 + i);
      rd(1'h0, 8'h60 + i[7:0], 32'h3C000000 + i);
    end
  endtask
  task automatic t_scratch;
    for (int i = 0; i < 8; i++)
      wr(1'h0, 8'h20 + i[7:0], 32'h11111111 * i);
    for (int i = 0; i < 8; i++)
      rd(1'h1, 8'h20 + i[7:0], 32'h11111111 * i);
    wr(1'h1, 8'h27, 32'hCAFE0027);
    rd(1'h0, 8'h27, 32'hCAFE0027);
  endtask
  task automatic t_ibreak;
    for (int i = 0; i < 4; i++)
      wr(1'h0, 8'h30 + i[7:0], 32'h1000 + 16 * i);
    wr(1'h0, 8'h40, 32'h00FF0000);
    take(2, 32'h1000, 3'h0, 1'h0, 1'h0, 32'h0);
    wr(1'h0, 8'h40, 32'h00020001);
    take(2, 32'h1000, 3'h0, 1'h0, 1'h0, 32'h0);
    take(2, 32'h1000, 3'h1, 1'h0, 1'h1, 32'h00000103);
    take(2, 32'h1004, 3'h1, 1'h0, 1'h0, 32'h0);
    wr(1'h0, 8'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(1'h0, 8'h40 + i[7:0], 32'h00FF0001);
      take(2, 32'h1000 + 16 * i, 3'(i + 2), 1'h0, 1'h1, (i << 16) | ((i + 2) << 8) | 3);
      wr(1'h0, 8'h40 + i[7:0], 32'h0);
    end
    wr(1'h0, 8'h32, 32'h2000);
    wr(1'h0, 8'h33, 32'h2000);
    wr(1'h0, 8'h42, 32'h00FF0001);
    wr(1'h0, 8'h43, 32'h00FF0001);
    take(2, 32'h2000, 3'h7, 1'h0, 1'h1, 32'h00020703);
    wr(1'h0, 8'h41, 32'h00FF0003);
    take(2, 32'h2000, 3'h7, 1'h0, 1'h1, 32'h00010703);
    take(2, 32'h1010, 3'h7, 1'h0, 1'h0, 32'h0);
    for (int i = 1; i < 4; i++)
      wr(1'h0, 8'h40 + i[7:0], 32'h0);
  endtask
  task automatic t_dwatch;
    wr(1'h0, 8'h50, 32'h100);
    wr(1'h0, 8'h60, 32'h1FF);
    wr(1'h0, 8'h70, 32'h00FF0005);
    take(3, 32'h180, 3'h3, 1'h1, 1'h1, 32'h00000304);
    take(3, 32'h180, 3'h3, 1'h0, 1'h0, 32'h0);
    take(3, 32'h200, 3'h3, 1'h1, 1'h0, 32'h0);
    wr(1'h0, 8'h70, 32'h00FF0007);
    take(3, 32'h200, 3'h3, 1'h1, 1'h1, 32'h00000304);
    wr(1'h0, 8'h70, 32'h0);
  endtask
  task automatic t_events;
    wr(1'h0, 8'h18, 32'hFFFFFF05);
    stop_exp = 8'h05;
    rd(1'h0, 8'h18, 32'h05);
    chk({24'h0, hold}, 32'h05);
    take(0, 32'h0, 3'h5, 1'h0, 1'h1, 32'h00000001);
    take(1, 32'h0, 3'h6, 1'h0, 1'h1, 32'h00000602);
    take(4, 32'hABCD0012, 3'h7, 1'h0, 1'h1, 32'h00020705);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'h1;
    t_regs();
    t_scratch();
    t_ibreak();
    t_dwatch();
    t_events();
    report_and_stop();
  end
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end
endmodule // debug_breakpoint_regs_tb_top
